// ### src/mpt_defines.svh
// timing and strap constants of the multiphase pwm timing block
// assumes inclusion from the package, design and verification files
`ifndef MPT_DEFINES_SVH
`define MPT_DEFINES_SVH

// switching period in ns, stands in for the frequency-set resistor
`define MPT_PERIOD_NS      2400
`define MPT_CLK_NS         40
// cycles per switching period (60 at 25 MHz)
`define MPT_PERIOD_CYC     (`MPT_PERIOD_NS / `MPT_CLK_NS)
// forced off time is a least time: one third of a period, rounded up
`define MPT_OFF_CYC        ((`MPT_PERIOD_CYC + 2) / 3)
// sample window opens one sixth after the fall, rounded up
`define MPT_SMP_OPEN_CYC   ((`MPT_PERIOD_CYC + 5) / 6)
// window is a longest time: one third, rounded down
`define MPT_SMP_LEN_CYC    (`MPT_PERIOD_CYC / 3)
`define MPT_CNT_W          8
`define MPT_CUR_W          12
`define MPT_NCH            4
// balance error filter shift
`define MPT_FILT_SH        2
`define MPT_CUR_RST        12'h0000

`endif

// ### src/mpt_pkg.sv
// types shared by the multiphase pwm timing design
// assumes mpt_defines.svh is on the include path
`include "mpt_defines.svh"

package mpt_pkg;
  typedef logic [`MPT_CUR_W-1:0] mpt_cur_t;
  typedef logic signed [`MPT_CUR_W:0] mpt_err_t;
  typedef logic [`MPT_CNT_W-1:0] mpt_cnt_t;

  // per-phase comparator inputs and sensed currents
  typedef struct packed {
    logic [`MPT_NCH-1:0] ramp_cross;
    mpt_cur_t [`MPT_NCH-1:0] sense;
  } mpt_sense_t;

  // per-phase held samples and balance errors
  typedef struct packed {
    mpt_cur_t [`MPT_NCH-1:0] held;
    mpt_err_t [`MPT_NCH-1:0] err;
  } mpt_bal_t;

  typedef enum logic [1:0] {
    MPT_ONE,
    MPT_TWO,
    MPT_THREE,
    MPT_FOUR
  } mpt_count_t;
endpackage

// ### src/mpt_hold_mem.sv
// held current samples, one word per phase, registered read
// assumes writes come only from the sampling windows of the top
`timescale 1ns/10ps
`include "mpt_defines.svh"

module mpt_hold_mem
  import mpt_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // write side
  input  wire logic [`MPT_NCH-1:0]  wr_en,
  input  wire mpt_cur_t [`MPT_NCH-1:0] wr_data,
  // read side
  output mpt_cur_t [`MPT_NCH-1:0]   rd_data
);
  mpt_cur_t [`MPT_NCH-1:0] mem_q, mem_d;

  always_comb begin
    mem_d = mem_q;
    for (int i = 0; i < `MPT_NCH; i++) begin
      if (wr_en[i]) begin
        mem_d[i] = wr_data[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_q <= '{default: `MPT_CUR_RST};
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rd_data = mem_q;
endmodule

// ### src/mpt_balance.sv
// average current and filtered per-phase balance error
// assumes held samples are stable for a whole switching cycle
`timescale 1ns/10ps
`include "mpt_defines.svh"

module mpt_balance
  import mpt_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // inputs
  input  wire logic [`MPT_NCH-1:0]  active,
  input  wire logic [2:0]           nact,
  input  wire mpt_cur_t [`MPT_NCH-1:0] held,
  // results
  output mpt_cur_t                  avg,
  output mpt_err_t [`MPT_NCH-1:0]   err
);
  mpt_cur_t avg_q, avg_d;
  mpt_err_t [`MPT_NCH-1:0] err_q, err_d;
  logic [`MPT_CUR_W+1:0] sum;
  mpt_err_t diff;
  logic signed [`MPT_CUR_W+1:0] diff_w, err_w, step;

  always_comb begin
    sum = '0;
    for (int i = 0; i < `MPT_NCH; i++) begin
      if (active[i]) begin
        sum = sum + {2'b00, held[i]};
      end
    end
    case (nact)
      3'd2:    avg_d = sum[`MPT_CUR_W:1];
      3'd3:    avg_d = `MPT_CUR_W'(sum / 3);
      3'd4:    avg_d = sum[`MPT_CUR_W+1:2];
      default: avg_d = sum[`MPT_CUR_W-1:0];
    endcase
    err_d = err_q;
    for (int i = 0; i < `MPT_NCH; i++) begin
      diff = $signed({1'b0, held[i]}) - $signed({1'b0, avg_q});
      // first-order filter: err += (diff - err) >> sh
      // one bit wider, a full-scale swing would wrap the difference
      diff_w = $signed(diff);
      err_w  = $signed(err_q[i]);
      step   = (diff_w - err_w) >>> `MPT_FILT_SH;
      if (active[i]) begin
        err_d[i] = err_q[i] + step[`MPT_CUR_W:0];
      end else begin
        err_d[i] = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      avg_q <= `MPT_CUR_RST;
      err_q <= '0;
    end else begin
      avg_q <= avg_d;
      err_q <= err_d;
    end
  end

  assign avg = avg_q;
  assign err = err_q;
endmodule

// ### src/mpt_top.sv
// multiphase pwm timing: phase termination, forced off time, sampling
// assumes comparator crossings and sensed currents arrive synchronous
`timescale 1ns/10ps
`include "mpt_defines.svh"

module mpt_top
  import mpt_pkg::*;
(
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESETN,
  // straps on the shared phase pins
  input  wire logic                  PHASE_THREE_OUT_STRAP_IN,
  input  wire logic                  PHASE_FOUR_OUT_STRAP_IN,
  // comparator crossings and sensed currents
  input  mpt_pkg::mpt_sense_t        SENSE,
  // phase outputs; enables low while driving
  output logic                       PHASE_ONE_OUT,
  output logic                       PHASE_TWO_OUT,
  output logic                       PHASE_THREE_OUT_STRAP_OUT,
  output logic                       PHASE_THREE_OUT_STRAP_OEN,
  output logic                       PHASE_FOUR_OUT_STRAP_OUT,
  output logic                       PHASE_FOUR_OUT_STRAP_OEN,
  // sampling windows and results
  output logic [`MPT_NCH-1:0]        SAMPLE_WINDOW,
  output mpt_pkg::mpt_bal_t          BALANCE,
  output mpt_pkg::mpt_cur_t          AVERAGE_PHASE_CURRENT,
  output mpt_pkg::mpt_cur_t          DROOP_CURRENT,
  output logic [1:0]                 PHASE_COUNT
);
  import mpt_pkg::*;

  localparam int PER  = `MPT_PERIOD_CYC;
  localparam int OFFC = `MPT_OFF_CYC;
  localparam int SOPN = `MPT_SMP_OPEN_CYC;
  localparam int SLEN = `MPT_SMP_LEN_CYC;

  // ****************************************************************
  // strap capture
  // ****************************************************************
  mpt_count_t cnt_q, cnt_d;

  function automatic mpt_count_t decode_straps(input logic s3,
                                               input logic s4);
    case ({s4, s3})
      2'b01:   return MPT_TWO;
      2'b10:   return MPT_THREE;
      2'b11:   return MPT_ONE;
      default: return MPT_FOUR;
    endcase
  endfunction

  function automatic logic [2:0] count_num(input mpt_count_t c);
    case (c)
      MPT_ONE:   return 3'd1;
      MPT_TWO:   return 3'd2;
      MPT_THREE: return 3'd3;
      default:   return 3'd4;
    endcase
  endfunction

  // straps are decoded only in reset, so the count is frozen after release
  always_comb begin
    cnt_d = cnt_q;
    if (!RESETN) begin
      cnt_d = decode_straps(PHASE_THREE_OUT_STRAP_IN,
                            PHASE_FOUR_OUT_STRAP_IN);
    end
  end

  always_ff @(posedge CLK) begin
    cnt_q <= cnt_d;
  end

  logic [2:0]          nact;
  logic [`MPT_NCH-1:0] active;
  assign nact = count_num(cnt_q);
  always_comb begin
    for (int i = 0; i < `MPT_NCH; i++) begin
      active[i] = (3'(i) < nact);
    end
  end

  // ****************************************************************
  // termination clock and phase offsets
  // ****************************************************************
  mpt_cnt_t tick_q, tick_d;

  // period equals the programmed switching period
  always_comb begin
    tick_d = (tick_q == mpt_cnt_t'(PER - 1)) ? '0 : tick_q + 8'h01;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_d;
    end
  end

  function automatic mpt_cnt_t phase_offset(input int ph,
                                            input logic [2:0] n);
    return mpt_cnt_t'((ph * PER) / n);
  endfunction

  logic [`MPT_NCH-1:0] term;
  always_comb begin
    for (int i = 0; i < `MPT_NCH; i++) begin
      // phase one at tick 0 starts the cycle
      term[i] = active[i] && (tick_q == phase_offset(i, nact));
    end
  end

  // ****************************************************************
  // per-phase pwm and sampling window
  // ****************************************************************
  logic [`MPT_NCH-1:0] pwm_q, pwm_d, win_q, win_d;
  mpt_cnt_t [`MPT_NCH-1:0] low_q, low_d;

  always_comb begin
    pwm_d = pwm_q;
    win_d = win_q;
    low_d = low_q;
    for (int i = 0; i < `MPT_NCH; i++) begin
      if (!active[i]) begin
        pwm_d[i] = 1'b0;
        win_d[i] = 1'b0;
        low_d[i] = '0;
      end else if (term[i]) begin
        pwm_d[i] = 1'b0;
        win_d[i] = 1'b0;
        low_d[i] = '0;
      end else if (!pwm_q[i]) begin
        // saturate so a phase that never rises cannot wrap the count
        if (low_q[i] != 8'hFF) begin
          low_d[i] = low_q[i] + 8'h01;
        end
        if (low_q[i] >= mpt_cnt_t'(OFFC - 1) &&
            SENSE.ramp_cross[i]) begin
          pwm_d[i] = 1'b1;
          win_d[i] = 1'b0;
        end else begin
          win_d[i] = (low_q[i] >= mpt_cnt_t'(SOPN - 1)) &&
                     (low_q[i] < mpt_cnt_t'(SOPN + SLEN - 1));
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pwm_q <= '0;
      win_q <= '0;
      low_q <= '0;
    end else begin
      pwm_q <= pwm_d;
      win_q <= win_d;
      low_q <= low_d;
    end
  end

  // ****************************************************************
  // sample hold and balance
  // ****************************************************************
  mpt_cur_t [`MPT_NCH-1:0] held;
  mpt_cur_t                avg;
  mpt_err_t [`MPT_NCH-1:0] err;

  // last window value stays until the next window
  mpt_hold_mem u_hold (
    .clk     (CLK),
    .resetn  (RESETN),
    .wr_en   (win_q & active),
    .wr_data (SENSE.sense),
    .rd_data (held)
  );

  mpt_balance u_bal (
    .clk    (CLK),
    .resetn (RESETN),
    .active (active),
    .nact   (nact),
    .held   (held),
    .avg    (avg),
    .err    (err)
  );

  // ****************************************************************
  // output registers
  // ****************************************************************
  logic [`MPT_NCH-1:0] out_q;
  logic [`MPT_NCH-1:0] oen_q, win_o_q;
  mpt_bal_t            bal_q;
  mpt_cur_t            avg_o_q;
  logic [1:0]          pc_q;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      out_q   <= '0;
      oen_q   <= 4'hF;
      win_o_q <= '0;
      bal_q   <= '0;
      avg_o_q <= `MPT_CUR_RST;
      pc_q    <= 2'h0;
    end else begin
      out_q   <= pwm_q;
      oen_q   <= ~active;
      win_o_q <= win_q;
      bal_q   <= '{held: held, err: err};
      avg_o_q <= avg;
      pc_q    <= 2'(nact - 3'd1);
    end
  end

  assign PHASE_ONE_OUT             = out_q[0];
  assign PHASE_TWO_OUT             = out_q[1];
  assign PHASE_THREE_OUT_STRAP_OUT = out_q[2];
  assign PHASE_THREE_OUT_STRAP_OEN = oen_q[2];
  assign PHASE_FOUR_OUT_STRAP_OUT  = out_q[3];
  assign PHASE_FOUR_OUT_STRAP_OEN  = oen_q[3];
  assign SAMPLE_WINDOW             = win_o_q;
  assign BALANCE                   = bal_q;
  assign AVERAGE_PHASE_CURRENT     = avg_o_q;
  assign DROOP_CURRENT             = avg_o_q;
  assign PHASE_COUNT               = pc_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_phase_one_term: assert property (
    tick_q == 8'h00 |=> !pwm_q[0]) else $error("phase one not dropped");
  a_forced_low: assert property (
    $fell(pwm_q[0]) |-> !pwm_q[0] [*8]) else $error("off time short");
  a_rise_cause: assert property (
    $rose(pwm_q[1]) |-> $past(SENSE.ramp_cross[1]))
    else $error("rise without crossing");
  a_high_hold: assert property (
    pwm_q[0] && !term[0] |=> pwm_q[0]) else $error("early fall");
  a_win_not_high: assert property (
    win_q[0] |-> !pwm_q[0]) else $error("window while high");
  a_disabled_quiet: assert property (
    !active[3] |-> !pwm_q[3] && !win_q[3]) else $error("idle phase live");
  a_count_fixed: assert property (
    $stable(cnt_q)) else $error("count changed");
  a_period: assert property (
    tick_q == 8'h00 |-> ##60 tick_q == 8'h00) else $error("bad period");
  a_held_stable: assert property (
    !win_q[0] |=> $stable(held[0])) else $error("held changed");

  // timing is checked on the counters, a short run would miss a small slip
  a_rise_after_off: assert property (
    $rose(pwm_q[0]) |-> $past(low_q[0]) >= mpt_cnt_t'(OFFC - 1))
    else $error("rise inside off time");
  a_win_open: assert property (
    $rose(win_q[0]) |-> $past(low_q[0]) == mpt_cnt_t'(SOPN - 1))
    else $error("window opened off time");
  a_win_len: assert property (
    win_q[1] |-> low_q[1] >= mpt_cnt_t'(SOPN) &&
                 low_q[1] <= mpt_cnt_t'(SOPN + SLEN - 1))
    else $error("window too long");
  a_quarter_offset: assert property (
    term[1] && nact == 3'd4 |-> tick_q == mpt_cnt_t'(PER / 4))
    else $error("bad quarter offset");
  a_half_offset: assert property (
    term[1] && nact == 3'd2 |-> tick_q == mpt_cnt_t'(PER / 2))
    else $error("bad half offset");
  a_third_offset: assert property (
    term[2] && nact == 3'd3 |-> tick_q == mpt_cnt_t'(2 * PER / 3))
    else $error("bad third offset");
  a_single_phase: assert property (
    nact == 3'd1 |-> pwm_q[3:1] == 3'b000)
    else $error("extra phase live");

  // ****************************************************************
  // scenario covers
  // ****************************************************************
  c_rise: cover property ($rose(pwm_q[0]));
  c_window: cover property ($rose(win_q[1]));
  c_two: cover property (cnt_q == MPT_TWO && $rose(pwm_q[1]));
  c_three: cover property (cnt_q == MPT_THREE && $rose(pwm_q[2]));
  c_single: cover property (cnt_q == MPT_ONE && $rose(pwm_q[0]));
endmodule

// ### verification/mpt_driver_model.sv
// driver stage model: turns pwm pins into ramp crossings and sensed current
// assumes the bench sets per-phase crossing delay and current level
`timescale 1ns/10ps
`include "mpt_defines.svh"

module mpt_driver_model
  import mpt_pkg::*;
(
  // clock
  input  wire logic                        clk,
  // resolved pwm pin levels
  input  wire logic [`MPT_NCH-1:0]         pwm,
  // behaviour chosen by the bench
  input  wire logic [`MPT_NCH-1:0][7:0]    cross_dly,
  input  wire mpt_pkg::mpt_cur_t [`MPT_NCH-1:0] cur,
  // comparator and sense back to the controller
  output mpt_pkg::mpt_sense_t              sense
);
  import mpt_pkg::*;

  int low_cnt [`MPT_NCH];

  initial sense = '0;

  // crossing may come early; the controller has to refuse it
  always @(posedge clk) begin
    #1;
    for (int k = 0; k < `MPT_NCH; k++) begin
      low_cnt[k] = pwm[k] ? 0 : low_cnt[k] + 1;
      sense.ramp_cross[k] = !pwm[k] && (low_cnt[k] >= int'(cross_dly[k]));
      // current only valid while the lower switch conducts
      sense.sense[k] = pwm[k] ? ~cur[k] : cur[k];
    end
  end
endmodule

// ### verification/tb_multiphase_pwm_timing.sv
// self-checking bench for the multiphase pwm timing block
// assumes straps are pulled to the bench strap level when released
`timescale 1ns/10ps
`include "mpt_defines.svh"

module tb_multiphase_pwm_timing;
  import mpt_pkg::*;
  localparam int PER = `MPT_PERIOD_CYC;
  localparam int OFF = `MPT_OFF_CYC;
  localparam int OPN = `MPT_SMP_OPEN_CYC;
  localparam int LEN = `MPT_SMP_LEN_CYC;

  logic             clk = 1'b0;
  logic             resetn = 1'b0;
  logic [1:0]       strap = 2'b00;
  logic [3:0]       pwm;
  logic             p3_out, p3_oen, p4_out, p4_oen;
  logic [3:0]       win;
  logic [1:0]       pcount;
  logic [3:0][7:0]  dly = '0;
  mpt_cur_t [3:0]   cur = '0;
  mpt_sense_t       sense;
  mpt_bal_t         bal;
  mpt_cur_t         avg, droop;
  logic [3:0]       pprev, wprev;
  int               fail_count = 0;
  int               check_count = 0;
  int               cyc = 0;
  int               n = 4;
  int               hi;
  int               el, el0, ofs, dmax;
  int               dfall [4];
  int               lfall [4];
  int               wopen [4];
  bit               run = 1'b0;

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  assign pwm[2] = p3_oen ? strap[0] : p3_out;
  assign pwm[3] = p4_oen ? strap[1] : p4_out;

  mpt_top i_mpt_top (
    .CLK                       (clk),
    .RESETN                    (resetn),
    .PHASE_THREE_OUT_STRAP_IN  (pwm[2]),
    .PHASE_FOUR_OUT_STRAP_IN   (pwm[3]),
    .SENSE                     (sense),
    .PHASE_ONE_OUT             (pwm[0]),
    .PHASE_TWO_OUT             (pwm[1]),
    .PHASE_THREE_OUT_STRAP_OUT (p3_out),
    .PHASE_THREE_OUT_STRAP_OEN (p3_oen),
    .PHASE_FOUR_OUT_STRAP_OUT  (p4_out),
    .PHASE_FOUR_OUT_STRAP_OEN  (p4_oen),
    .SAMPLE_WINDOW             (win),
    .BALANCE                   (bal),
    .AVERAGE_PHASE_CURRENT     (avg),
    .DROOP_CURRENT             (droop),
    .PHASE_COUNT               (pcount)
  );

  mpt_driver_model i_mpt_driver_model (
    .clk       (clk),
    .pwm       (pwm),
    .cross_dly (dly),
    .cur       (cur),
    .sense     (sense)
  );

  // ****************************************
  // compare and report
  // ****************************************
  task automatic cmp_val(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cmp_time(input string what, input int lo, input int hi,
                          input int got);
    check_count++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // edge timing monitor
  // ****************************************
  always @(negedge clk) begin
    if (run) begin
      for (int k = 0; k < n; k++) begin
        el  = cyc - lfall[k];
        el0 = cyc - lfall[0];
        ofs = k * PER / n;
        if (pprev[k] && !pwm[k]) begin
          if (lfall[k] >= 0)
            cmp_time("phase period", PER, PER, el);
          if (k > 0 && lfall[0] >= 0)
            cmp_time("phase offset", ofs, ofs, el0);
          lfall[k] = cyc;
          dfall[k] = int'(dly[k]);
        end
        if (!pprev[k] && pwm[k] && lfall[k] >= 0) begin
          // a delay changed while low may decide the rise either way
          dmax = (dfall[k] > int'(dly[k])) ? dfall[k] : int'(dly[k]);
          hi = (dmax + 3 > OFF) ? dmax + 4 : OFF + 1;
          cmp_time("forced low time", OFF, hi, el);
        end
        if (!wprev[k] && win[k] && lfall[k] >= 0)
          cmp_time("window open", OPN - 1, OPN, cyc - lfall[k]);
        if (!wprev[k] && win[k])
          wopen[k] = cyc;
        if (wprev[k] && !win[k] && wopen[k] >= 0 && lfall[k] >= 0)
          cmp_time("window length", OFF - OPN, LEN, cyc - wopen[k]);
        if (pwm[k])
          cmp_val("window while high", 16'h0000, 16'(win[k]));
      end
      pprev = pwm;
      wprev = win;
    end
  end

  // ****************************************
  // behavioural model of the results
  // ****************************************
  task automatic check_results;
    int q [$];
    int sum;
    int diff;
    for (int k = 0; k < n; k++)
      q.push_back(int'(cur[k]));
    sum = q.sum();
    cmp_val("phase count", 16'(n - 1), 16'(pcount));
    cmp_val("average", 16'(sum / n), 16'(avg));
    cmp_val("droop", 16'(sum / n), 16'(droop));
    cmp_val("oen three", 16'(n < 3), 16'(p3_oen));
    cmp_val("oen four", 16'(n < 4), 16'(p4_oen));
    for (int k = 0; k < 4; k++) begin
      diff = int'(cur[k]) - sum / n;
      if (k < n) begin
        cmp_val("held sample", 16'(cur[k]), 16'(bal.held[k]));
        if (diff > 64)
          cmp_val("error sign", 16'h0000, 16'(bal.err[k][12]));
        if (diff < -64)
          cmp_val("error sign", 16'h0001, 16'(bal.err[k][12]));
      end else begin
        cmp_val("unused held", 16'h0000, 16'(bal.held[k]));
        cmp_val("unused error", 16'h0000, 16'(bal.err[k]));
        cmp_val("unused window", 16'h0000, 16'(win[k]));
      end
    end
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    void'($urandom(32'ha96c));
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      #1;
      run = 1'b0;
      resetn = 1'b0;
      strap = t[1:0];
      n = (t == 0) ? 4 : (t == 1) ? 2 : (t == 2) ? 3 : 1;
      // mid-run the phase pins need one edge to let go before straps show
      repeat ((t == 0) ? 1 : 3) @(posedge clk);
      #1;
      resetn = 1'b1;
      lfall = '{-1, -1, -1, -1};
      wopen = '{-1, -1, -1, -1};
      pprev = pwm;
      wprev = win;
      // two current sets per strap setting, so each active phase's held sample is replaced
      for (int h = 0; h < 2; h++) begin
        for (int k = 0; k < 4; k++) begin
          dly[k] = 8'($urandom_range(35, 0));
          cur[k] = 12'($urandom);
        end
        run = 1'b1;
        repeat (6 * PER) @(posedge clk);
        #1;
        check_results();
      end
      $display("test %0d with %0d phases done", t, n);
    end
    complete_run();
  end

  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule
